// ===== nfi_defines.svh
// Offsets, field positions, reset values and sizes of the checksum and injection registers
`ifndef NFI_DEFINES_SVH
`define NFI_DEFINES_SVH

`define NFI_CMD_CRC        8'hf0
`define NFI_CMD_INJECT     8'hf1
`define NFI_CRC_POLY       16'h8005
`define NFI_CRC_INIT       16'h0000
`define NFI_INJ_RESET      16'h0000
`define NFI_NVM_BYTES      64
`define NFI_NVM_AW         6
// Longest busy span after a trigger: rest of a running pass plus one queued pass
`define NFI_CRC_PASS_MAX   10'h110
`define NFI_BIT_FHOLD      15
`define NFI_BIT_F_OTEMP    14
`define NFI_BIT_F_OCUR     12
`define NFI_BIT_F_INLOCK   11
`define NFI_BIT_F_INOV     10
`define NFI_BIT_F_OUTUV    9
`define NFI_BIT_F_OUTOV    8
`define NFI_BIT_WHOLD      7
`define NFI_BIT_W_OCUR     4
`define NFI_BIT_W_INUV     3
`define NFI_BIT_W_OUTUV    1
`define NFI_BIT_W_OUTOV    0
// Fault positions allowed while conversion is off: input lockout, output overvoltage
`define NFI_FMASK_CONV_OFF 6'b00_1001

`endif

// ===== nfi_pkg.sv
// Types shared by the checksum and injection register bank
package nfi_pkg;

    typedef struct packed {
        logic [7:0]  code;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } nfi_cmd_t;

    typedef struct packed {
        logic        ack;
        logic        nack;
        logic [15:0] rdata;
    } nfi_rsp_t;

    // Order: otemp, ocur, in_lock, in_ov, out_uv, out_ov
    typedef struct packed {
        logic otemp;
        logic ocur;
        logic in_lock;
        logic in_ov;
        logic out_uv;
        logic out_ov;
    } nfi_fault_t;

    typedef struct packed {
        logic ocur;
        logic in_uv;
        logic out_uv;
        logic out_ov;
    } nfi_warn_t;

    typedef enum logic [3:0] {
        CRC_IDLE  = 4'b0001,
        CRC_FETCH = 4'b0010,
        CRC_ACC   = 4'b0100,
        CRC_DONE  = 4'b1000
    } nfi_crc_state_t;

endpackage

// ===== nfi_crc_engine.sv
// Walks the settings memory and folds each byte into a CRC-16
`timescale 1ns/100ps
`include "nfi_defines.svh"

module nfi_crc_engine (
    input  wire logic                   i_clk_sys,     // System clock
    input  wire logic                   i_sys_rst,     // Async reset, high
    input  wire logic                   i_start,       // Start pulse, taken in idle
    output logic      [`NFI_NVM_AW-1:0] o_nvm_rd_addr, // Settings byte address
    input  wire logic [7:0]             i_nvm_rd_data, // Byte, one cycle after address
    output logic                        o_idle,        // Engine ready for start
    output logic                        o_done,        // One-cycle result pulse
    output logic      [15:0]            o_crc          // Finished checksum
);
    import nfi_pkg::*;

    nfi_crc_state_t         state_r;
    logic [`NFI_NVM_AW-1:0] addr_r;
    logic [15:0]            acc_r;

    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ `NFI_CRC_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= CRC_IDLE;
        end else begin
            case (state_r)
                CRC_IDLE:  state_r <= i_start ? CRC_FETCH : CRC_IDLE;
                CRC_FETCH: state_r <= CRC_ACC;
                CRC_ACC:   state_r <= (addr_r == `NFI_NVM_AW'(`NFI_NVM_BYTES - 1)) ?
                                      CRC_DONE : CRC_FETCH;
                CRC_DONE:  state_r <= CRC_IDLE;
                default:   state_r <= CRC_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            addr_r <= '0;
            acc_r  <= `NFI_CRC_INIT;
        end else if (state_r == CRC_IDLE && i_start) begin
            addr_r <= '0;
            acc_r  <= `NFI_CRC_INIT;
        end else if (state_r == CRC_ACC) begin
            acc_r  <= crc_byte(acc_r, i_nvm_rd_data);
            addr_r <= addr_r + 1'b1;
        end
    end

    // result at last byte
    // Final value must stand while the done pulse stands, or the bank latches a stale pass
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_crc <= `NFI_CRC_INIT;
        end else if (state_r == CRC_ACC && addr_r == `NFI_NVM_AW'(`NFI_NVM_BYTES - 1)) begin
            o_crc <= crc_byte(acc_r, i_nvm_rd_data);
        end
    end

    assign o_nvm_rd_addr = addr_r;
    assign o_idle        = (state_r == CRC_IDLE);
    assign o_done        = (state_r == CRC_DONE);

    a_crc_start_fetch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_idle && i_start) |=> state_r == CRC_FETCH && addr_r == '0)
        else $error("engine did not begin at byte zero");
    a_crc_walk_len: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(state_r == CRC_DONE) |-> $past(addr_r) == `NFI_NVM_AW'(`NFI_NVM_BYTES - 1))
        else $error("checksum ended before last byte");

endmodule // nfi_crc_engine

// ===== nfi_reg_bank.sv
// Settings checksum word and fault injection word of the power stage command set
//
// Contract
// - Checksum is CRC-16, polynomial 0x8005, over current settings, read by command.
// - Checksum recomputed at boot and after each store or restore completes.
// - Checksum fills bits 15:0, word read only, writes refused.
// - Fault hold 0 clears simulated faults after one response; 1 holds until rewrite.
// - Warning hold 0 clears simulated warnings after one response; 1 holds until rewrite.
// - Bits 14,12,11,10 inject overtemp, overcurrent, input lockout, input overvoltage.
// - Bit 9 injects output undervoltage fault, bit 8 output overvoltage fault.
// - Bits 4,3,1,0 inject overcurrent, input UV, output UV, output OV warnings.
// - Conversion off: only input lockout and output overvoltage are forced.
// - Other conditions act only while conversion on, repeating with fault hold.
// - Several injection bits in one write are simulated together.
// - Each condition forces its detector output into normal response logic.
`timescale 1ns/100ps
`include "nfi_defines.svh"

module nfi_reg_bank (
    input  wire logic                   i_clk_sys,          // System clock, 250 MHz
    input  wire logic                   i_sys_rst,          // Async reset, high
    input  wire nfi_pkg::nfi_cmd_t      i_cmd,              // Decoded command strobes
    output nfi_pkg::nfi_rsp_t           o_rsp,              // Registered answer
    input  wire logic                   i_conv_en,          // Conversion enabled, same clock
    input  wire logic                   i_fault_resp,       // Fault response taken, pulse
    input  wire logic                   i_warn_resp,        // Warning response taken, pulse
    input  wire logic                   i_nvm_store_done,   // Settings store finished, pulse
    input  wire logic                   i_nvm_restore_done, // Settings restore finished, pulse
    output logic      [`NFI_NVM_AW-1:0] o_nvm_rd_addr,      // Settings byte address
    input  wire logic [7:0]             i_nvm_rd_data,      // Settings byte, 1 cycle later
    output logic                        o_crc_busy,         // Checksum being recomputed
    output nfi_pkg::nfi_fault_t         o_fault_force,      // Forced fault detectors
    output nfi_pkg::nfi_warn_t          o_warn_force        // Forced warning detectors
);
    import nfi_pkg::*;

    logic [15:0] crc_word_r;
    logic [15:0] inj_word_r;
    logic        crc_pend_r;
    logic        eng_idle;
    logic        eng_done;
    logic [15:0] eng_crc;
    nfi_fault_t  fault_act_r;
    nfi_fault_t  fault_act_nxt;
    nfi_warn_t   warn_act_r;
    nfi_warn_t   warn_act_nxt;
    logic        hit_crc;
    logic        hit_inj;
    logic        inj_wr;

    function automatic nfi_fault_t fault_bits(input logic [15:0] w);
        return '{otemp: w[`NFI_BIT_F_OTEMP], ocur: w[`NFI_BIT_F_OCUR],
                 in_lock: w[`NFI_BIT_F_INLOCK], in_ov: w[`NFI_BIT_F_INOV],
                 out_uv: w[`NFI_BIT_F_OUTUV], out_ov: w[`NFI_BIT_F_OUTOV]};
    endfunction

    function automatic nfi_warn_t warn_bits(input logic [15:0] w);
        return '{ocur: w[`NFI_BIT_W_OCUR], in_uv: w[`NFI_BIT_W_INUV],
                 out_uv: w[`NFI_BIT_W_OUTUV], out_ov: w[`NFI_BIT_W_OUTOV]};
    endfunction

    assign hit_crc = (i_cmd.code == `NFI_CMD_CRC);
    assign hit_inj = (i_cmd.code == `NFI_CMD_INJECT);
    assign inj_wr  = hit_inj && i_cmd.wr;

    // boot and store/restore trigger
    // Reset value 1 makes the boot recompute; a done pulse while busy queues one more pass
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            crc_pend_r <= 1'b1;
        end else if (i_nvm_store_done || i_nvm_restore_done) begin
            crc_pend_r <= 1'b1;
        end else if (eng_idle) begin
            crc_pend_r <= 1'b0;
        end
    end

    nfi_crc_engine u_crc (
        .i_clk_sys     (i_clk_sys),
        .i_sys_rst     (i_sys_rst),
        .i_start       (crc_pend_r),
        .o_nvm_rd_addr (o_nvm_rd_addr),
        .i_nvm_rd_data (i_nvm_rd_data),
        .o_idle        (eng_idle),
        .o_done        (eng_done),
        .o_crc         (eng_crc)
    );

    // checksum word update
    // Old value stays readable during a recompute rather than a partial one
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            crc_word_r <= `NFI_CRC_INIT;
        end else if (eng_done) begin
            crc_word_r <= eng_crc;
        end
    end

    assign o_crc_busy = crc_pend_r || !eng_idle;

    // pass length watch
    // Restarts on each trigger, so a queued pass stays inside the bound
    logic [9:0] busy_cnt_r;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_cnt_r <= '0;
        end else if (!o_crc_busy || i_nvm_store_done || i_nvm_restore_done) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            inj_word_r <= `NFI_INJ_RESET;
        end else if (inj_wr) begin
            inj_word_r <= i_cmd.wdata;
        end
    end

    // auto clear after one response; a write in the same cycle wins
    always_comb begin
        fault_act_nxt = fault_act_r;
        warn_act_nxt  = warn_act_r;
        if (i_fault_resp && !inj_word_r[`NFI_BIT_FHOLD]) begin
            fault_act_nxt = '0;
        end
        if (i_warn_resp && !inj_word_r[`NFI_BIT_WHOLD]) begin
            warn_act_nxt = '0;
        end
        if (inj_wr) begin
            fault_act_nxt = fault_bits(i_cmd.wdata);
            warn_act_nxt  = warn_bits(i_cmd.wdata);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fault_act_r <= '0;
            warn_act_r  <= '0;
        end else begin
            fault_act_r <= fault_act_nxt;
            warn_act_r  <= warn_act_nxt;
        end
    end

    // conversion gating of detector forces
    // Held-off requests stay pending and take effect once conversion starts
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fault_force <= '0;
            o_warn_force  <= '0;
        end else begin
            o_fault_force <= i_conv_en ? fault_act_r : (fault_act_r & `NFI_FMASK_CONV_OFF);
            o_warn_force  <= i_conv_en ? warn_act_r : '0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rsp <= '0;
        end else begin
            o_rsp.ack  <= (hit_crc && i_cmd.rd) || (hit_inj && (i_cmd.rd || i_cmd.wr));
            o_rsp.nack <= hit_crc && i_cmd.wr;
            if (hit_crc && i_cmd.rd) begin
                o_rsp.rdata <= crc_word_r;
            end else if (hit_inj && i_cmd.rd) begin
                o_rsp.rdata <= inj_word_r;
            end
        end
    end

    sequence s_crc_trigger;
        i_nvm_store_done || i_nvm_restore_done;
    endsequence

    sequence s_crc_busy_seen;
        ##1 o_crc_busy;
    endsequence

    a_recalc_on_store: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        s_crc_trigger |-> s_crc_busy_seen)
        else $error("store or restore did not start a checksum pass");
    a_crc_pass_bound: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        busy_cnt_r <= `NFI_CRC_PASS_MAX)
        else $error("checksum pass did not finish in time");
    a_crc_read_value: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (hit_crc && i_cmd.rd) |=> o_rsp.ack && o_rsp.rdata == $past(crc_word_r))
        else $error("checksum read returned wrong word");
    a_crc_write_refused: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (hit_crc && i_cmd.wr && !i_cmd.rd) |=> o_rsp.nack && !o_rsp.ack)
        else $error("checksum write not refused");
    a_inject_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (hit_inj && i_cmd.rd) |=> o_rsp.ack && o_rsp.rdata == $past(inj_word_r))
        else $error("injection word read back wrong");

    a_fault_autoclear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_fault_resp && !inj_word_r[15] && !inj_wr) |=> fault_act_r == '0)
        else $error("simulated fault survived its response");
    a_fault_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (inj_word_r[15] && !inj_wr) |=> fault_act_r == $past(fault_act_r))
        else $error("held fault changed without a write");
    a_warn_autoclear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_warn_resp && !inj_word_r[7] && !inj_wr) |=> warn_act_r == '0)
        else $error("simulated warning survived its response");
    a_warn_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (inj_word_r[`NFI_BIT_WHOLD] && !inj_wr) |=> warn_act_r == $past(warn_act_r))
        else $error("held warning changed without a write");
    a_inject_bits: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        inj_wr |=> fault_act_r == {$past(i_cmd.wdata[14]), $past(i_cmd.wdata[12:8])}
                   && warn_act_r == {$past(i_cmd.wdata[4:3]), $past(i_cmd.wdata[1:0])})
        else $error("injection bits not captured together");

    a_conv_off_mask: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_conv_en |=> !o_fault_force.otemp && !o_fault_force.ocur && !o_fault_force.in_ov
                       && !o_fault_force.out_uv && o_warn_force == '0)
        else $error("held-off condition forced while conversion off");
    a_force_follows: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_conv_en |=> o_fault_force == $past(fault_act_r)
                      && o_warn_force == $past(warn_act_r))
        else $error("detector force does not follow active set");
    a_lockout_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_conv_en |=> o_fault_force.in_lock == $past(fault_act_r.in_lock)
                       && o_fault_force.out_ov == $past(fault_act_r.out_ov))
        else $error("allowed fault not forced while conversion off");

endmodule // nfi_reg_bank

// ===== nfi_nvm_model.sv
// Settings memory model answering byte fetches one cycle after the address
`timescale 1ns/100ps
`include "nfi_defines.svh"

module nfi_nvm_model (
    input  wire logic [`NFI_NVM_AW-1:0] i_addr,    // Byte address
    input  wire logic                   i_clk_sys, // System clock
    input  wire logic [7:0]             i_key,     // Selects memory contents
    output logic      [7:0]             o_data     // Byte, one cycle later
);
    // Contents follow the key, so a store or restore changes every byte
    always_ff @(posedge i_clk_sys) begin
        o_data <= ({2'b00, i_addr} * 8'h3b) ^ i_key;
    end
endmodule // nfi_nvm_model

// ===== nfi_reg_bank_test.sv
// Self-checking bench of the checksum and fault injection registers
`timescale 1ns/100ps
`include "nfi_defines.svh"

module nfi_reg_bank_test;
    import nfi_pkg::*;
    logic                   i_clk_sys = 1'b0;
    logic                   rst       = 1'b1;
    nfi_cmd_t               cmd       = '0;
    nfi_rsp_t               rsp;
    logic                   conv_en   = 1'b1;
    logic                   f_resp    = 1'b0;
    logic                   w_resp    = 1'b0;
    logic                   store     = 1'b0;
    logic                   restore   = 1'b0;
    logic [`NFI_NVM_AW-1:0] addr;
    logic [7:0]             nvm_data;
    logic [7:0]             key       = 8'h00;
    logic                   busy;
    nfi_fault_t             ff;
    nfi_warn_t              wf;
    int                     errors          = 0;
    int                     samples_checked = 0;

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    errors++; $display("Error %s expected %h seen %h", nm, ex, got); end end

    always #2 i_clk_sys = ~i_clk_sys;

    nfi_reg_bank dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(rst), .i_cmd(cmd), .o_rsp(rsp),
        .i_conv_en(conv_en), .i_fault_resp(f_resp), .i_warn_resp(w_resp),
        .i_nvm_store_done(store), .i_nvm_restore_done(restore),
        .o_nvm_rd_addr(addr), .i_nvm_rd_data(nvm_data), .o_crc_busy(busy),
        .o_fault_force(ff), .o_warn_force(wf)
    );

    nfi_nvm_model mem (.i_addr(addr), .i_clk_sys(i_clk_sys), .i_key(key), .o_data(nvm_data));

    // Reference checksum: MSB first, zero start, no reflection
    function automatic logic [15:0] crc_exp(input logic [7:0] k);
        logic [15:0] c;
        logic [7:0]  b;
        c = 16'h0000;
        for (int i = 0; i < `NFI_NVM_BYTES; i++) begin
            b = (8'(i) * 8'h3b) ^ k;
            for (int j = 7; j >= 0; j--) begin
                c = (c[15] ^ b[j]) ? ({c[14:0], 1'b0} ^ `NFI_CRC_POLY) : {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    task settle();
        @(posedge i_clk_sys);
        #1;
    endtask

    // One strobe cycle; answer is looked at in the cycle after
    task run_cmd(input logic [7:0] code, input logic wr, input logic [15:0] wd);
        settle();
        cmd = '{code: code, wr: wr, rd: !wr, wdata: wd};
        settle();
        cmd = '0;
    endtask

    task pulse(input int sel);
        settle();
        case (sel)
            0: store = 1'b1;
            1: restore = 1'b1;
            2: f_resp = 1'b1;
            default: w_resp = 1'b1;
        endcase
        settle();
        {store, restore, f_resp, w_resp} = 4'h0;
    endtask

    task wait_crc();
        for (int n = 0; n < 300 && busy !== 1'b0; n++) settle();
        `CHK("crc busy", 1'b0, busy)
    endtask

    task write_inj(input logic [15:0] wd);
        run_cmd(`NFI_CMD_INJECT, 1'b1, wd);
        `CHK("inject ack", 1'b1, rsp.ack)
        settle();
    endtask

    task t_boot();
        `CHK("busy in reset", 1'b1, busy)
        `CHK("faults in reset", 6'h00, ff)
        repeat (10) @(posedge i_clk_sys);
        #1 rst = 1'b0;
        run_cmd(`NFI_CMD_CRC, 1'b0, 16'h0000);
        `CHK("early crc", 16'h0000, rsp.rdata)
        wait_crc();
        run_cmd(`NFI_CMD_CRC, 1'b0, 16'h0000);
        `CHK("boot crc ack", 1'b1, rsp.ack)
        `CHK("boot crc", crc_exp(8'h00), rsp.rdata)
    endtask

    task t_crc_refused();
        run_cmd(`NFI_CMD_CRC, 1'b1, 16'h1234);
        `CHK("crc write nack", 1'b1, rsp.nack)
        `CHK("crc write ack", 1'b0, rsp.ack)
        run_cmd(`NFI_CMD_CRC, 1'b0, 16'h0000);
        `CHK("crc unchanged", crc_exp(8'h00), rsp.rdata)
    endtask

    task t_store_restore();
        for (int s = 0; s < 2; s++) begin
            key = 8'h5a + 8'(s);
            pulse(s);
            `CHK("busy after trigger", 1'b1, busy)
            wait_crc();
            run_cmd(`NFI_CMD_CRC, 1'b0, 16'h0000);
            `CHK("updated crc", crc_exp(key), rsp.rdata)
        end
    endtask

    task automatic t_single_bits();
        int fb[6] = '{8, 9, 10, 11, 12, 14};
        int wb[4] = '{0, 1, 3, 4};
        for (int i = 0; i < 6; i++) begin
            write_inj(16'h8000 | (16'h0001 << fb[i]));
            `CHK("single fault", 6'(1 << i), ff)
            `CHK("no warning", 4'h0, wf)
        end
        for (int i = 0; i < 4; i++) begin
            write_inj(16'h0080 | (16'h0001 << wb[i]));
            `CHK("single warning", 4'(1 << i), wf)
            `CHK("no fault", 6'h00, ff)
        end
    endtask

    task t_multi_reserved();
        write_inj(16'hdf9b);
        `CHK("all faults", 6'h3f, ff)
        `CHK("all warnings", 4'hf, wf)
        write_inj(16'h2064);
        `CHK("unused fault", 6'h00, ff)
        `CHK("unused warning", 4'h0, wf)
        run_cmd(`NFI_CMD_INJECT, 1'b0, 16'h0000);
        `CHK("inject readback", 16'h2064, rsp.rdata)
    endtask

    task t_auto_clear();
        write_inj(16'h5f1b);
        `CHK("set faults", 6'h3f, ff)
        pulse(2);
        settle();
        `CHK("faults cleared", 6'h00, ff)
        `CHK("warnings kept", 4'hf, wf)
        pulse(3);
        settle();
        `CHK("warnings cleared", 4'h0, wf)
        write_inj(16'hdf9b);
        pulse(2);
        pulse(3);
        settle();
        `CHK("faults held", 6'h3f, ff)
        `CHK("warnings held", 4'hf, wf)
    endtask

    task t_conv_off();
        conv_en = 1'b0;
        write_inj(16'hdf9b);
        `CHK("faults conv off", 6'h09, ff)
        `CHK("warnings conv off", 4'h0, wf)
        conv_en = 1'b1;
        settle();
        `CHK("faults conv on", 6'h3f, ff)
        `CHK("warnings conv on", 4'hf, wf)
    endtask

    task stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #1;
        t_boot();
        t_crc_refused();
        t_store_restore();
        t_single_bits();
        t_multi_reserved();
        t_auto_clear();
        t_conv_off();
        stop_test();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule // nfi_reg_bank_test
